// *** rtl/ccrs_defines.svh ***
`ifndef CCRS_DEFINES_SVH
`define CCRS_DEFINES_SVH

// Register offsets (byte addresses, one word each)
`define CCRS_OFS_ZERO   8'h00
`define CCRS_OFS_ONE    8'h04
`define CCRS_OFS_TWO    8'h08
`define CCRS_OFS_THREE  8'h0c
`define CCRS_OFS_FOUR   8'h10
`define CCRS_OFS_CFG2   8'h14
`define CCRS_OFS_ISTAT  8'h18
`define CCRS_OFS_IMASK  8'h1c

// Register zero fields
`define CCRS_BIT_PG     31
`define CCRS_BIT_CD     30
`define CCRS_BIT_NW     29
`define CCRS_BIT_AM     18
`define CCRS_BIT_PE     0
`define CCRS_ZERO_WMASK 32'he004_002f
`define CCRS_ZERO_RST   32'h0000_0010
`define CCRS_ZERO_ONES  32'h0000_0010

// Register four and three fields
`define CCRS_BIT_TSP    2
`define CCRS_TSP_RST    1'b1
`define CCRS_DIR_MSB    31
`define CCRS_DIR_LSB    12

// Configuration control two: write-back select lock
`define CCRS_BIT_NWLOCK 2

// Interrupt status bits
`define CCRS_IRQ_W      4
`define CCRS_EV_TSFLT   0
`define CCRS_EV_PFCAP   1
`define CCRS_EV_ALIGN   2
`define CCRS_EV_NWREF   3

`endif

// *** rtl/ccrs_pkg.sv ***
`default_nettype none

package ccrs_pkg;

   // Cache events reported by the L1 controller
   typedef struct packed {
      logic fill_req;
      logic rd_hit;
      logic wr_req;
      logic wr_hit;
      logic wr_locked;
      logic evict_mod;
      logic flush_evict;
      logic snoop_inval;
   } ccrs_cache_req_t;

   // Cache permissions returned to the controller
   typedef struct packed {
      logic fill_grant;
      logic rd_serve;
      logic line_update;
      logic ext_write;
      logic inval_go;
   } ccrs_cache_resp_t;

   // Privileged instruction checks
   typedef struct packed {
      logic       ts_req;
      logic [1:0] cur_priv_level;
      logic       uncond_branch;
      logic       align_req;
      logic       misaligned;
      logic       alignment_check_flag;
   } ccrs_core_req_t;

endpackage

`default_nettype wire

// *** rtl/ccrs_regs.sv ***
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ccrs_defines.svh"

module ccrs_regs
   import ccrs_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [31:0]            reg_rdata,
   // Core side
   input  wire ccrs_core_req_t    core_req,
   input  wire logic              page_fault,
   input  wire logic [31:0]       fault_addr,
   input  wire ccrs_cache_req_t   cache_req,
   output ccrs_cache_resp_t       cache_resp,
   output logic                   ts_grant,
   output logic                   ts_fault,
   output logic                   align_fault,
   output logic                   protected_mode,
   output logic                   paging_enable,
   output logic [19:0]            directory_base_field,
   output logic                   irq
);

   // ****************************************************
   // Helper functions
   // ****************************************************

   // Address match, used by every decode term
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction

   // Write-one-to-clear with set priority
   function automatic logic [`CCRS_IRQ_W-1:0] w1c(
      input logic [`CCRS_IRQ_W-1:0] cur,
      input logic [`CCRS_IRQ_W-1:0] set,
      input logic [`CCRS_IRQ_W-1:0] clr);
      w1c = (cur & ~clr) | set;
   endfunction

   // ****************************************************
   // Register state
   // ****************************************************

   logic [31:0]            zero_q;
   logic [31:0]            zero_d;
   logic [31:0]            two_q;
   logic [31:0]            two_d;
   logic [19:0]            three_q;
   logic                   tsp_q;
   logic                   nwlock_q;
   logic                   pg_taken_q;
   logic [`CCRS_IRQ_W-1:0] istat_q;
   logic [`CCRS_IRQ_W-1:0] istat_d;
   logic [`CCRS_IRQ_W-1:0] imask_q;
   logic [31:0]            rdata_d;
   logic [31:0]            rdata_q;

   // Registered outputs
   ccrs_cache_resp_t       resp_q;
   ccrs_cache_resp_t       resp_d;
   logic                   ts_grant_q;
   logic                   ts_fault_q;
   logic                   align_fault_q;
   logic                   pmode_q;
   logic                   paging_q;
   logic                   irq_q;

   // ****************************************************
   // Address decode
   // ****************************************************

   wire logic sel_zero  = hit(reg_addr, `CCRS_OFS_ZERO);
   wire logic sel_one   = hit(reg_addr, `CCRS_OFS_ONE);
   wire logic sel_two   = hit(reg_addr, `CCRS_OFS_TWO);
   wire logic sel_three = hit(reg_addr, `CCRS_OFS_THREE);
   wire logic sel_four  = hit(reg_addr, `CCRS_OFS_FOUR);
   wire logic sel_cfg2  = hit(reg_addr, `CCRS_OFS_CFG2);
   wire logic sel_istat = hit(reg_addr, `CCRS_OFS_ISTAT);
   wire logic sel_imask = hit(reg_addr, `CCRS_OFS_IMASK);

   wire logic wr_zero  = reg_wr & sel_zero;
   wire logic wr_two   = reg_wr & sel_two;
   wire logic wr_three = reg_wr & sel_three;
   wire logic wr_four  = reg_wr & sel_four;
   wire logic wr_cfg2  = reg_wr & sel_cfg2;
   wire logic wr_istat = reg_wr & sel_istat;
   wire logic wr_imask = reg_wr & sel_imask;

   // ****************************************************
   // Register zero update
   // ****************************************************

   // Only documented fields take writes; bits 28:19 stay zero
   wire logic [31:0] zero_wmask = `CCRS_ZERO_WMASK;

   // Attempt to flip write-back select while locked
   wire logic nw_change = reg_wdata[`CCRS_BIT_NW] != zero_q[`CCRS_BIT_NW];
   wire logic nw_refused = wr_zero & nwlock_q & nw_change;

   // Locked write-back select keeps its old value
   wire logic [31:0] zero_wmask_eff = nwlock_q ?
      (zero_wmask & ~(32'h1 << `CCRS_BIT_NW)) : zero_wmask;

   always_comb begin
      zero_d = zero_q;
      if (wr_zero) begin
         zero_d = (zero_q & ~zero_wmask_eff)
                | (reg_wdata & zero_wmask_eff)
                | `CCRS_ZERO_ONES;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         zero_q <= `CCRS_ZERO_RST;
      end else begin
         zero_q <= zero_d;
      end
   end

   // Named fields of register zero
   wire logic pg_bit = zero_q[`CCRS_BIT_PG];
   wire logic cd_bit = zero_q[`CCRS_BIT_CD];
   wire logic nw_bit = zero_q[`CCRS_BIT_NW];
   wire logic am_bit = zero_q[`CCRS_BIT_AM];
   wire logic pe_bit = zero_q[`CCRS_BIT_PE];

   // ****************************************************
   // Paging and mode control
   // ****************************************************

   // Paging bit sampled only at an unconditional branch, so the
   // prefetched stream before the branch still sees the old mode
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pg_taken_q <= 1'b0;
      end else if (core_req.uncond_branch) begin
         pg_taken_q <= pg_bit;
      end
   end

   // Protection off drops paging at once, without waiting
   wire logic paging_on = pg_taken_q & pe_bit;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pmode_q  <= 1'b0;
         paging_q <= 1'b0;
      end else begin
         pmode_q  <= pe_bit;
         paging_q <= paging_on;
      end
   end

   // ****************************************************
   // Fault address register
   // ****************************************************

   // Hardware capture wins over a same-cycle software write
   wire logic pf_capture = page_fault & paging_on;

   always_comb begin
      two_d = two_q;
      if (pf_capture) begin
         two_d = fault_addr;
      end else if (wr_two) begin
         two_d = reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         two_q <= 32'h0000_0000;
      end else begin
         two_q <= two_d;
      end
   end

   // ****************************************************
   // Directory base, timestamp gate and lock
   // ****************************************************

   // Only the 4 KB aligned base is stored; low bits not kept
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         three_q <= 20'h0_0000;
      end else if (wr_three) begin
         three_q <= reg_wdata[`CCRS_DIR_MSB:`CCRS_DIR_LSB];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tsp_q <= `CCRS_TSP_RST;
      end else if (wr_four) begin
         tsp_q <= reg_wdata[`CCRS_BIT_TSP];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         nwlock_q <= 1'b0;
      end else if (wr_cfg2) begin
         nwlock_q <= reg_wdata[`CCRS_BIT_NWLOCK];
      end
   end

   // ****************************************************
   // Instruction checks
   // ****************************************************

   // Restricted mode admits only the most privileged level
   wire logic ts_ok = ~tsp_q | (core_req.cur_priv_level == 2'h0);
   wire logic ts_ok_ev  = core_req.ts_req & ts_ok;
   wire logic ts_bad_ev = core_req.ts_req & ~ts_ok;

   // Mask bit gates the flag; a cleared mask blocks every fault
   wire logic al_ev = core_req.align_req & core_req.misaligned
                    & core_req.alignment_check_flag & am_bit;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ts_grant_q    <= 1'b0;
         ts_fault_q    <= 1'b0;
         align_fault_q <= 1'b0;
      end else begin
         ts_grant_q    <= ts_ok_ev;
         ts_fault_q    <= ts_bad_ev;
         align_fault_q <= al_ev;
      end
   end

   // ****************************************************
   // Cache policy
   // ****************************************************

   // Write-back: hits stay local unless locked
   wire logic wb_core_wr = cache_req.wr_req
                         & (~cache_req.wr_hit | cache_req.wr_locked);
   wire logic wb_evict   = cache_req.evict_mod | cache_req.flush_evict;
   wire logic wb_ext     = wb_core_wr | wb_evict;
   // Write-through: no dirty lines, so no eviction traffic
   wire logic wt_ext     = cache_req.wr_req;

   always_comb begin
      resp_d             = '0;
      resp_d.fill_grant  = cache_req.fill_req & ~cd_bit;
      resp_d.rd_serve    = cache_req.rd_hit;
      resp_d.line_update = cache_req.wr_req & cache_req.wr_hit;
      resp_d.inval_go    = cache_req.snoop_inval;
      resp_d.ext_write   = nw_bit ? wb_ext : wt_ext;
   end

   // Fills stopped here do not flush the cache; software must
   // invalidate it itself for a complete shutdown
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         resp_q <= '0;
      end else begin
         resp_q <= resp_d;
      end
   end

   // ****************************************************
   // Interrupt status and mask
   // ****************************************************

   wire logic [`CCRS_IRQ_W-1:0] ev_set = {nw_refused, al_ev,
                                          pf_capture, ts_bad_ev};
   wire logic [`CCRS_IRQ_W-1:0] ev_clr = wr_istat ?
      reg_wdata[`CCRS_IRQ_W-1:0] : '0;

   always_comb begin
      istat_d = w1c(istat_q, ev_set, ev_clr);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         istat_q <= '0;
      end else begin
         istat_q <= istat_d;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         imask_q <= '0;
      end else if (wr_imask) begin
         imask_q <= reg_wdata[`CCRS_IRQ_W-1:0];
      end
   end

   // Level output follows the new status, one cycle behind events
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(istat_d & imask_q);
      end
   end

   // ****************************************************
   // Read data
   // ****************************************************

   // Reserved bits of register four read as zero
   wire logic [31:0] four_rd = 32'(tsp_q) << `CCRS_BIT_TSP;
   wire logic [31:0] three_rd = {three_q, 12'h000};
   wire logic [31:0] cfg2_rd  = 32'(nwlock_q) << `CCRS_BIT_NWLOCK;

   // Register one and unmapped offsets answer zero
   always_comb begin
      if (sel_zero) begin
         rdata_d = zero_q;
      end else if (sel_one) begin
         rdata_d = 32'h0000_0000;
      end else if (sel_two) begin
         rdata_d = two_q;
      end else if (sel_three) begin
         rdata_d = three_rd;
      end else if (sel_four) begin
         rdata_d = four_rd;
      end else if (sel_cfg2) begin
         rdata_d = cfg2_rd;
      end else if (sel_istat) begin
         rdata_d = 32'(istat_q);
      end else if (sel_imask) begin
         rdata_d = 32'(imask_q);
      end else begin
         rdata_d = 32'h0000_0000;
      end
   end

   // Data valid only in the cycle after the strobe
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   // ****************************************************
   // Output assignments
   // ****************************************************

   assign reg_rdata            = rdata_q;
   assign cache_resp           = resp_q;
   assign ts_grant             = ts_grant_q;
   assign ts_fault             = ts_fault_q;
   assign align_fault          = align_fault_q;
   assign protected_mode       = pmode_q;
   assign paging_enable        = paging_q;
   assign directory_base_field = three_q;
   assign irq                  = irq_q;

endmodule

`default_nettype wire

// *** verif/ccrs_regs_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none

module ccrs_regs_mon
   import ccrs_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [31:0]       reg_rdata,
   input wire ccrs_core_req_t    core_req,
   input wire ccrs_cache_req_t   cache_req,
   input wire ccrs_cache_resp_t  cache_resp,
   input wire logic              ts_grant,
   input wire logic              ts_fault,
   input wire logic              align_fault,
   input wire logic              protected_mode,
   input wire logic              paging_enable,
   input wire logic [19:0]       directory_base_field
);
   // ***************
   // Control shadows
   // ***************
   logic tsp_q, pgb_q, pmode_q, inh_q, wbs_q, alm_q, lock_q;
   wire logic wr_zero = reg_wr && reg_addr == 8'h00;

   // Mirrors only the bits the checks need, not the whole map
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {pgb_q, pmode_q, inh_q, wbs_q, alm_q, lock_q} <= '0;
         tsp_q <= 1'b1;
      end else begin
         if (wr_zero) begin
            {pgb_q, inh_q} <= reg_wdata[31:30];
            alm_q <= reg_wdata[18];
            pmode_q <= reg_wdata[0];
         end
         if (wr_zero && !lock_q) wbs_q <= reg_wdata[29];
         if (reg_wr && reg_addr == 8'h10) tsp_q <= reg_wdata[2];
         if (reg_wr && reg_addr == 8'h14) lock_q <= reg_wdata[2];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_rd_four; reg_rd && reg_addr == 8'h10; endsequence
   sequence s_quiet; !reg_wr [*2]; endsequence
   sequence s_branch_quiet; core_req.uncond_branch && !reg_wr ##1 !reg_wr; endsequence

   property p_four_rsvd; s_rd_four |=> reg_rdata[31:3] == '0 && reg_rdata[1:0] == 2'h0; endproperty
   a_four_rsvd: assert property (p_four_rsvd) else $error("reserved bits read nonzero");
   property p_ts;
      core_req.ts_req |=> ts_grant == !($past(tsp_q) && $past(core_req.cur_priv_level) != 2'h0)
         && ts_fault == !ts_grant;
   endproperty
   a_ts: assert property (p_ts) else $error("timestamp gate wrong");
   property p_dir; reg_wr && reg_addr == 8'h0c |=> directory_base_field == $past(reg_wdata[31:12]); endproperty
   a_dir: assert property (p_dir) else $error("directory base not loaded");
   property p_pg_wait;
      wr_zero && reg_wdata[31] && reg_wdata[0] == protected_mode && !$past(reg_wr) && !paging_enable
         && !core_req.uncond_branch && !$past(core_req.uncond_branch) |=> ##1 !paging_enable;
   endproperty
   a_pg_wait: assert property (p_pg_wait) else $error("paging changed without branch");
   property p_pg_take; s_branch_quiet |=> paging_enable == (pgb_q && pmode_q); endproperty
   a_pg_take: assert property (p_pg_take) else $error("paging state wrong after branch");
   property p_prot; s_quiet |-> protected_mode == pmode_q; endproperty
   a_prot: assert property (p_prot) else $error("protected mode mismatch");
   property p_fill; cache_req.fill_req |=> cache_resp.fill_grant == !$past(inh_q); endproperty
   a_fill: assert property (p_fill) else $error("fill grant wrong");
   property p_hits;
      cache_req.rd_hit || cache_req.snoop_inval |=> cache_resp.rd_serve == $past(cache_req.rd_hit)
         && cache_resp.inval_go == $past(cache_req.snoop_inval);
   endproperty
   a_hits: assert property (p_hits) else $error("hit or snoop not served");
   property p_wr;
      cache_req.wr_req |=> cache_resp.ext_write == (!$past(wbs_q) || !$past(cache_req.wr_hit)
         || $past(cache_req.wr_locked) || $past(cache_req.evict_mod) || $past(cache_req.flush_evict));
   endproperty
   a_wr: assert property (p_wr) else $error("external write wrong");
   property p_align;
      core_req.align_req |=> align_fault == ($past(core_req.misaligned)
         && $past(core_req.alignment_check_flag) && $past(alm_q));
   endproperty
   a_align: assert property (p_align) else $error("alignment fault wrong");
endmodule

bind ccrs_regs ccrs_regs_mon #(.ADDR_W(ADDR_W)) mon_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .core_req, .cache_req, .cache_resp, .ts_grant, .ts_fault, .align_fault,
   .protected_mode, .paging_enable, .directory_base_field);

`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none

module testbench
   import ccrs_pkg::*;
;
   logic             clk, sys_rst, reg_wr, reg_rd, page_fault;
   logic [7:0]       reg_addr;
   logic [31:0]      reg_wdata, fault_addr, reg_rdata;
   ccrs_core_req_t   core_req, cr_v;
   ccrs_cache_req_t  cache_req;
   ccrs_cache_resp_t cache_resp;
   logic             ts_grant, ts_fault, align_fault, protected_mode, paging_enable, irq;
   logic [19:0]      directory_base_field;
   int               miscompares = 0, cmp_count = 0, cycles = 0;
   // Cache cases: 0..6 with fill inhibit and write-back, 7..9 with neither
   logic [7:0] req_tab [10] = '{8'hc0, 8'h30, 8'h20, 8'h38, 8'h04, 8'h02, 8'h01, 8'h80, 8'h30, 8'h04};
   logic [4:0] exp_tab [10] = '{5'h08, 5'h04, 5'h02, 5'h06, 5'h02, 5'h02, 5'h01, 5'h10, 5'h06, 5'h00};

   ccrs_regs #(.ADDR_W(8)) dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .core_req, .page_fault, .fault_addr, .cache_req, .cache_resp, .ts_grant, .ts_fault, .align_fault,
      .protected_mode, .paging_enable, .directory_base_field, .irq);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ***************
   // Tasks
   // ***************
   task end_sim;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask

   task core(input ccrs_core_req_t r);
      @(posedge clk);
      core_req <= r;
      @(posedge clk);
      core_req <= '0;
      #1;
   endtask

   task pf(input logic [31:0] a);
      @(posedge clk);
      page_fault <= 1'b1;
      fault_addr <= a;
      @(posedge clk);
      page_fault <= 1'b0;
   endtask

   task cache(input int i);
      @(posedge clk);
      cache_req <= ccrs_cache_req_t'(req_tab[i]);
      @(posedge clk);
      cache_req <= '0;
      #1 check(cache_resp, exp_tab[i]);
   endtask

   // Hang guard, run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         end_sim();
      end
   end

   // ***************
   // Sequence
   // ***************
   initial begin
      {sys_rst, reg_wr, reg_rd, page_fault} = 4'h8;
      {reg_addr, reg_wdata, fault_addr} = '0;
      {core_req, cache_req, cr_v} = '0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(8'h00, 32'h0000_0010);
      rdc(8'h10, 32'h0000_0004);
      wr(8'h10, 32'hffff_ffff);
      rdc(8'h10, 32'h0000_0004);
      for (int i = 0; i < 8; i++) begin
         if (i == 4) wr(8'h10, 32'h0);
         cr_v = '0;
         cr_v.ts_req = 1'b1;
         cr_v.cur_priv_level = i[1:0];
         core(cr_v);
         check({ts_grant, ts_fault}, (i > 0 && i < 4) ? 2'b01 : 2'b10);
      end
      wr(8'h0c, 32'hffff_ffff);
      rdc(8'h0c, 32'hffff_f000);
      check(directory_base_field, 20'hfffff);
      wr(8'h04, 32'hffff_ffff);
      rdc(8'h04, 32'h0);
      wr(8'h00, 32'h1ff8_0000);
      rdc(8'h00, 32'h0000_0010);
      rdc(8'h20, 32'h0);
      $display("test registers done");
      wr(8'h18, 32'hf);
      wr(8'h1c, 32'h2);
      wr(8'h00, 32'h1);
      wr(8'h00, 32'h8000_0001);
      repeat (2) @(posedge clk);
      #1 check(protected_mode, 1'b1);
      check(paging_enable, 1'b0);
      pf(32'h1111_1000);
      rdc(8'h08, 32'h0);
      cr_v = '0;
      cr_v.uncond_branch = 1'b1;
      core(cr_v);
      @(posedge clk);
      #1 check(paging_enable, 1'b1);
      pf(32'h8765_4321);
      rdc(8'h08, 32'h8765_4321);
      rdc(8'h18, 32'h2);
      check(irq, 1'b1);
      wr(8'h18, 32'h2);
      @(posedge clk);
      #1 check(irq, 1'b0);
      wr(8'h00, 32'h8000_0000);
      repeat (2) @(posedge clk);
      #1 check(paging_enable, 1'b0);
      pf(32'h2222_3000);
      rdc(8'h08, 32'h8765_4321);
      $display("test paging done");
      wr(8'h00, 32'h6000_0000);
      for (int i = 0; i < 7; i++) cache(i);
      wr(8'h14, 32'h4);
      wr(8'h00, 32'h0);
      rdc(8'h00, 32'h2000_0010);
      rdc(8'h18, 32'h8);
      wr(8'h14, 32'h0);
      wr(8'h00, 32'h0);
      rdc(8'h00, 32'h0000_0010);
      for (int i = 7; i < 10; i++) cache(i);
      $display("test cache done");
      cr_v = '0;
      {cr_v.align_req, cr_v.misaligned, cr_v.alignment_check_flag} = 3'h7;
      wr(8'h00, 32'h0004_0000);
      core(cr_v);
      check(align_fault, 1'b1);
      wr(8'h00, 32'h0);
      core(cr_v);
      check(align_fault, 1'b0);
      check(irq, 1'b0);
      $display("test alignment done");
      end_sim();
   end
endmodule

`default_nettype wire
